// File: core/watchdog_interval_timer.sv
// Watchdog / interval timer: fuse capture, registers, feed check, reset sequencer
//
// Operation
// - Counts from independent on-chip RC oscillator
// - Watchdog mode resets CPU, cannot be stopped
// - Fuse off: interval timer with interrupt, no reset
// - Eight periods, 16 ms to 2.1 s
// - Watchdog mode: control register writable once
// - Expires even when CPU clock stops
// - Held inactive during other chip resets
// - Feed is 1Eh then E1h to feed
// - Other instructions may sit between feed writes
// - Wrong feed ignored, timeout unchanged
// - Expiry resets CPU about one microsecond
// - From power-down, wait for stable oscillator
// - Config bit 7 is watchdog enable fuse
// - Config byte fixed at power-up, readable FD00h
`timescale 1ns/1ps
`include "wdt_regs.svh"
module watchdog_interval_timer (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        rc_osc_pin,     // RC oscillator output
  input  wire logic [7:0]  cfg_byte_pins,  // Configuration byte one from EPROM
  input  wire logic        other_rst_pin,  // Power-on, brownout or pin reset active
  input  wire logic        power_down,     // CPU in power-down
  input  wire logic        osc_stable,     // Main oscillator stable
  input  wire logic        reg_wr,         // Register write strobe
  input  wire logic        reg_rd,         // Register read strobe
  input  wire logic [15:0] reg_addr,       // Register address
  input  wire logic [7:0]  reg_wdata,      // Write data
  output wire logic [7:0]  reg_rdata,      // Read data
  output wire logic        cpu_reset,      // Internal chip reset request
  output wire logic        osc_start,      // Restart main oscillator
  output wire logic        timer_irq       // Interval interrupt request
);

  localparam int RST_CYC = (`WDT_RST_PULSE_NS + `WDT_CLK_NS - 1) / `WDT_CLK_NS;

  //------------------------------------------------------------
  // Declarations
  //------------------------------------------------------------
  wdt_if bus ();                            // Link to tick counter

  logic [7:0]  cfg_s1_ff;                   // Fuse synchroniser stage 1
  logic [7:0]  cfg_s2_ff;                   // Fuse synchroniser stage 2
  logic [2:0]  ext_s1_ff;                   // Status synchroniser stage 1
  logic [2:0]  ext_s2_ff;                   // Status synchroniser stage 2
  logic [7:0]  cfg_ff;                      // Captured configuration byte
  logic        captured_ff;                 // Configuration taken
  wdt_pkg::sel_t sel_ff;                    // Timeout select field
  logic        locked_ff;                   // Control write used up
  logic        flag_ff;                     // Interval expiry flag
  logic        armed_ff;                    // First feed key seen
  logic        pd_lat_ff;                   // Expired in power-down
  logic [5:0]  pulse_cnt_ff;                // Reset pulse length count
  wdt_pkg::rst_state_t state_ff;            // Reset sequencer state
  wdt_pkg::rst_state_t nxt_state;
  logic        cpu_reset_ff;                // Reset output register
  logic        osc_start_ff;                // Oscillator start register
  logic [7:0]  rdata_ff;                    // Read data register
  logic [7:0]  nxt_rdata;

  logic        other_rst;                   // Synchronised other reset
  logic        pd_sync;                     // Synchronised power-down
  logic        stable_sync;                 // Synchronised oscillator stable
  logic        wd_mode;                     // Watchdog operation enabled
  logic        wr_ctrl;                     // Write to control register
  logic        wr_feed;                     // Write to feed register
  logic        ctrl_ok;                     // Control write accepted
  logic        feed_ok;                     // Valid feed completed
  logic        flag_clr;                    // Software clears flag
  logic        flag_set;                    // Interval expiry
  logic        wd_expire;                   // Watchdog expiry
  logic        leave_rst;                   // Reset sequence ends

  //------------------------------------------------------------
  // Input synchronisers
  //------------------------------------------------------------
  // Two stages for every pin-side input
  always_ff @(posedge clk_sys) begin
    cfg_s1_ff <= cfg_byte_pins;
    cfg_s2_ff <= cfg_s1_ff;
    ext_s1_ff <= {osc_stable, power_down, other_rst_pin};
    ext_s2_ff <= ext_s1_ff;
  end

  assign other_rst   = ext_s2_ff[0];
  assign pd_sync     = ext_s2_ff[1];
  assign stable_sync = ext_s2_ff[2];

  //------------------------------------------------------------
  // Decode
  //------------------------------------------------------------
  assign wd_mode   = captured_ff & cfg_ff[`WDT_FUSE_BIT];
  assign wr_ctrl   = reg_wr && (reg_addr == `WDT_CTRL_ADDR);
  assign wr_feed   = reg_wr && (reg_addr == `WDT_FEED_ADDR);
  assign ctrl_ok   = wr_ctrl && !(wd_mode && locked_ff);
  assign feed_ok   = wr_feed && armed_ff && (reg_wdata == `WDT_FEED_KEY2);
  assign flag_clr  = ctrl_ok && !reg_wdata[`WDT_FLAG_BIT];
  assign flag_set  = bus.expire && !wd_mode && captured_ff;
  assign wd_expire = bus.expire && wd_mode && (state_ff == wdt_pkg::ST_RUN);
  assign leave_rst = (state_ff != wdt_pkg::ST_RUN) && (nxt_state == wdt_pkg::ST_RUN);

  // Counter control: no software path stops the count
  assign bus.restart = feed_ok || leave_rst;
  assign bus.hold    = !captured_ff || other_rst
                       || (state_ff != wdt_pkg::ST_RUN);
  assign bus.sel     = sel_ff;

  //------------------------------------------------------------
  // Configuration capture
  //------------------------------------------------------------
  // Taken once after reset release, never written by software
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_ff      <= `WDT_CFG1_RESET;
      captured_ff <= 1'b0;
    end else if (!captured_ff) begin
      cfg_ff      <= cfg_s2_ff;
      captured_ff <= 1'b1;
    end
  end

  //------------------------------------------------------------
  // Control and feed registers
  //------------------------------------------------------------
  // Select field, write-once lock and feed arming
  always_ff @(posedge clk_sys) begin
    if (srst || leave_rst) begin
      sel_ff    <= `WDT_SEL_RESET;
      locked_ff <= 1'b0;
      armed_ff  <= 1'b0;
    end else begin
      if (ctrl_ok) begin
        sel_ff <= reg_wdata[2:0];
      end
      if (wr_ctrl) begin
        locked_ff <= 1'b1;
      end
      if (wr_feed) begin
        armed_ff <= (reg_wdata == `WDT_FEED_KEY1);
      end
    end
  end

  // Flag: a set in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= flag_set || (flag_ff && !flag_clr);
    end
  end

  //------------------------------------------------------------
  // Reset sequencer
  //------------------------------------------------------------
  // Pulse, then optional wait for the main oscillator
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      wdt_pkg::ST_RUN: begin
        if (wd_expire) begin
          nxt_state = wdt_pkg::ST_RST_PULSE;
        end
      end
      wdt_pkg::ST_RST_PULSE: begin
        if (pulse_cnt_ff == 6'(RST_CYC - 1)) begin
          if (pd_lat_ff) begin
            nxt_state = wdt_pkg::ST_OSC_WAIT;
          end else begin
            nxt_state = wdt_pkg::ST_RUN;
          end
        end
      end
      wdt_pkg::ST_OSC_WAIT: begin
        if (stable_sync) begin
          nxt_state = wdt_pkg::ST_RUN;
        end
      end
      default: nxt_state = wdt_pkg::ST_RUN;
    endcase
  end

  // State, pulse count and output registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff     <= wdt_pkg::ST_RUN;
      pulse_cnt_ff <= 6'h00;
      pd_lat_ff    <= 1'b0;
      cpu_reset_ff <= 1'b0;
      osc_start_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      pulse_cnt_ff <= (state_ff == wdt_pkg::ST_RST_PULSE) ? pulse_cnt_ff + 6'h01 : 6'h00;
      if (wd_expire) begin
        pd_lat_ff <= pd_sync;
      end
      cpu_reset_ff <= (nxt_state != wdt_pkg::ST_RUN);
      osc_start_ff <= (nxt_state == wdt_pkg::ST_OSC_WAIT);
    end
  end

  //------------------------------------------------------------
  // Read port
  //------------------------------------------------------------
  // Read data mux; unmapped reads return zero
  always_comb begin
    if (reg_addr == `WDT_CFG1_ADDR) begin
      nxt_rdata = cfg_ff;
    end else if (reg_addr == `WDT_CTRL_ADDR) begin
      nxt_rdata = {1'b0, wd_mode, locked_ff, flag_ff, 1'b0, sel_ff};
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  // Read data register, updated on read strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign cpu_reset = cpu_reset_ff;
  assign osc_start = osc_start_ff;
  assign timer_irq = flag_ff;

  //------------------------------------------------------------
  // Tick counter
  //------------------------------------------------------------
  wdt_tick_counter u_counter (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .rc_osc_pin (rc_osc_pin),
    .bus        (bus.cnt)
  );

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  property p_rst_pulse_len;
    @(posedge clk_sys) disable iff (srst)
      $rose(cpu_reset_ff) && !pd_lat_ff |-> ##39 cpu_reset_ff ##1 !cpu_reset_ff;
  endproperty
  a_rst_pulse_len: assert property (p_rst_pulse_len)
    else $error("reset pulse not 40 cycles");

  property p_wd_expire_resets;
    @(posedge clk_sys) disable iff (srst)
      wd_expire |=> cpu_reset_ff && !flag_ff;
  endproperty
  a_wd_expire_resets: assert property (p_wd_expire_resets)
    else $error("watchdog expiry gave no reset");

  property p_interval_no_reset;
    @(posedge clk_sys) disable iff (srst)
      flag_set |=> flag_ff && !cpu_reset_ff;
  endproperty
  a_interval_no_reset: assert property (p_interval_no_reset)
    else $error("interval expiry wrong");

  property p_write_once;
    @(posedge clk_sys) disable iff (srst)
      wd_mode && locked_ff && wr_ctrl && !leave_rst |=> $stable(sel_ff);
  endproperty
  a_write_once: assert property (p_write_once)
    else $error("locked select changed");

  property p_bad_feed;
    @(posedge clk_sys) disable iff (srst)
      wr_feed && (!armed_ff || reg_wdata != `WDT_FEED_KEY2) && !leave_rst |-> !bus.restart;
  endproperty
  a_bad_feed: assert property (p_bad_feed)
    else $error("wrong feed restarted the count");

  property p_arm_kept;
    @(posedge clk_sys) disable iff (srst)
      armed_ff && reg_wr && reg_addr != `WDT_FEED_ADDR && !leave_rst |=> armed_ff;
  endproperty
  a_arm_kept: assert property (p_arm_kept)
    else $error("feed arming lost by other write");

  property p_other_rst_hold;
    @(posedge clk_sys) disable iff (srst)
      other_rst |-> bus.hold ##1 !bus.expire;
  endproperty
  a_other_rst_hold: assert property (p_other_rst_hold)
    else $error("timer active during other reset");

  property p_osc_wait;
    @(posedge clk_sys) disable iff (srst)
      state_ff == wdt_pkg::ST_OSC_WAIT && !stable_sync |=> cpu_reset_ff && osc_start_ff;
  endproperty
  a_osc_wait: assert property (p_osc_wait)
    else $error("reset released before oscillator stable");

  property p_cfg_fixed;
    @(posedge clk_sys) disable iff (srst)
      captured_ff |=> $stable(cfg_ff);
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed)
    else $error("configuration changed after capture");

  property p_fuse_off;
    @(posedge clk_sys) disable iff (srst)
      captured_ff && !cfg_ff[`WDT_FUSE_BIT] && bus.expire |=> !cpu_reset_ff;
  endproperty
  a_fuse_off: assert property (p_fuse_off)
    else $error("programmed fuse still reset");

endmodule // watchdog_interval_timer

// File: pkg/wdt_regs.svh
// Register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// Register addresses
`define WDT_CFG1_ADDR     16'hFD00
`define WDT_CTRL_ADDR     16'h00A7
`define WDT_FEED_ADDR     16'h00A6

// Reset values
`define WDT_CFG1_RESET    8'hFF
`define WDT_SEL_RESET     3'h0

// Field positions
`define WDT_FUSE_BIT      7
`define WDT_FLAG_BIT      4
`define WDT_LOCK_BIT      5
`define WDT_MODE_BIT      6

// Feed keys
`define WDT_FEED_KEY1     8'h1E
`define WDT_FEED_KEY2     8'hE1

// Oscillator ticks in the shortest (16 ms) period
`define WDT_BASE_TICKS    16'h0010

// Timing
`define WDT_CLK_NS        25
`define WDT_RST_PULSE_NS  1000

`endif

// File: pkg/wdt_pkg.sv
// Types shared by the watchdog modules
`include "wdt_regs.svh"
package wdt_pkg;

  // Timeout select code
  typedef logic [2:0] sel_t;

  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_RST_PULSE,
    ST_OSC_WAIT
  } rst_state_t;

  // Ticks of the selected period, doubling per select step
  function automatic logic [15:0] period_ticks(input sel_t sel);
    period_ticks = `WDT_BASE_TICKS << sel;
  endfunction

endpackage

// File: pkg/wdt_if.sv
// Control and expiry signals between the watchdog core and its tick counter
`timescale 1ns/1ps
interface wdt_if;
  logic             restart; // Clear count, one-cycle pulse
  logic             hold;    // Keep count at zero
  wdt_pkg::sel_t    sel;     // Selected period
  logic             expire;  // Period elapsed, one-cycle pulse

  modport ctl (output restart, output hold, output sel, input expire);
  modport cnt (input restart, input hold, input sel, output expire);
endinterface

// File: core/wdt_tick_counter.sv
// Period counter clocked by ticks of the free-running on-chip RC oscillator
`timescale 1ns/1ps
`include "wdt_regs.svh"
module wdt_tick_counter (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic rc_osc_pin,
  wdt_if.cnt        bus
);

  //------------------------------------------------------------
  // Oscillator synchroniser and edge detect
  //------------------------------------------------------------
  logic        rc_s1_ff;   // First stage, read only by second
  logic        rc_s2_ff;   // Second stage
  logic        rc_s3_ff;   // Delayed copy for edge detect
  logic        tick;       // Rising edge of oscillator
  logic [15:0] count_ff;   // Ticks elapsed in this period
  logic [15:0] nxt_count;
  logic        expire_ff;  // Expiry pulse
  logic        at_end;     // Last tick of the period

  // Sample the oscillator into this clock
  always_ff @(posedge clk_sys) begin
    rc_s1_ff <= rc_osc_pin;
    rc_s2_ff <= rc_s1_ff;
    rc_s3_ff <= rc_s2_ff;
  end

  assign tick   = rc_s2_ff & ~rc_s3_ff;
  assign at_end = tick && (count_ff == wdt_pkg::period_ticks(bus.sel) - 16'h0001);

  //------------------------------------------------------------
  // Count
  //------------------------------------------------------------
  // Restart beats hold, hold beats ticking
  always_comb begin
    if (bus.restart || bus.hold) begin
      nxt_count = 16'h0000;
    end else if (at_end) begin
      nxt_count = 16'h0000;
    end else if (tick) begin
      nxt_count = count_ff + 16'h0001;
    end else begin
      nxt_count = count_ff;
    end
  end

  // Counter and expiry pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_ff  <= 16'h0000;
      expire_ff <= 1'b0;
    end else begin
      count_ff  <= nxt_count;
      expire_ff <= at_end && !bus.restart && !bus.hold;
    end
  end

  assign bus.expire = expire_ff;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  property p_restart_clears;
    @(posedge clk_sys) disable iff (srst)
      bus.restart |=> (count_ff == 16'h0000) && !expire_ff;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("restart did not clear the count");

  property p_expire_at_period;
    @(posedge clk_sys) disable iff (srst)
      expire_ff |-> $past(count_ff) == wdt_pkg::period_ticks($past(bus.sel)) - 16'h0001;
  endproperty
  a_expire_at_period: assert property (p_expire_at_period)
    else $error("expiry not at the selected period");

  property p_hold_no_expire;
    @(posedge clk_sys) disable iff (srst)
      bus.hold |=> !expire_ff && count_ff == 16'h0000;
  endproperty
  a_hold_no_expire: assert property (p_hold_no_expire)
    else $error("counter ran while held");

endmodule // wdt_tick_counter

// File: test/watchdog_interval_timer_tb.sv
// Self-checking bench for the watchdog / interval timer
`timescale 1ns/1ps
`include "wdt_regs.svh"
module watchdog_interval_timer_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_sys;        // System clock, 40 MHz
  logic        srst;           // Synchronous reset
  logic        rc_osc_pin;     // Rc oscillator, driven by the bench
  logic [7:0]  cfg_byte_pins;  // Configuration byte one
  logic        other_rst_pin;  // Other chip reset active
  logic        power_down;     // CPU power-down
  logic        osc_stable;     // Main oscillator stable
  logic        reg_wr;         // Write strobe
  logic        reg_rd;         // Read strobe
  logic [15:0] reg_addr;       // Register address
  logic [7:0]  reg_wdata;      // Write data
  wire  [7:0]  reg_rdata;      // Read data
  wire         cpu_reset;      // Watchdog reset request
  wire         osc_start;      // Oscillator restart
  wire         timer_irq;      // Interval flag
  int          err_total;      // Mismatches
  int          num_checks;     // Comparisons
  int          ticks;          // Rc rising edges sent
  logic        rc_run;         // Rc toggling allowed
  logic        rd_flag;        // Read taken at last edge
  logic [31:0] rng;            // Xorshift state
  logic [7:0]  exp_q[$];       // Expected read data
  string       name_q[$];      // Names of pending reads

  // ----------------------------------------
  // Design under test
  // ----------------------------------------
  watchdog_interval_timer u_watchdog_interval_timer (
    .clk_sys(clk_sys), .srst(srst), .rc_osc_pin(rc_osc_pin),
    .cfg_byte_pins(cfg_byte_pins), .other_rst_pin(other_rst_pin),
    .power_down(power_down), .osc_stable(osc_stable), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cpu_reset(cpu_reset), .osc_start(osc_start),
    .timer_irq(timer_irq)
  );

  // ----------------------------------------
  // Clock, rc oscillator, read monitor
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Rc half period of 4 cycles; stands low when stopped
  initial begin
    int ph;
    ph = 0;
    forever begin
      @(negedge clk_sys);
      ph = ph + 1;
      if (ph == 4) begin
        ph = 0;
        if (rc_run || rc_osc_pin) begin
          rc_osc_pin = ~rc_osc_pin;
          ticks = ticks + rc_osc_pin;
        end
      end
    end
  end

  // Oldest note compared when read data appears
  always @(posedge clk_sys) rd_flag <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_flag === 1'b1 && exp_q.size() > 0) begin
      chk(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] xrand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string what);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    name_q.push_back(what);
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask

  // Key one, a foreign write, then key two
  task automatic feed(input logic [15:0] mid_a, input logic [7:0] mid_d);
    wr(`WDT_FEED_ADDR, `WDT_FEED_KEY1);
    wr(mid_a, mid_d);
    wr(`WDT_FEED_ADDR, `WDT_FEED_KEY2);
  endtask

  // Bounded wait for reset (irq=0) or flag (irq=1); tick count at arrival
  task automatic wait_hi(input bit irq, input int lim, output int t);
    int n;
    n = 0;
    while (((irq ? timer_irq : cpu_reset) !== 1'b1) && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("unexpected wait on output %0d: expected 1, seen 0", irq);
    end
    #1;
    t = ticks;
  endtask

  // Cycles for which cpu_reset stays high
  task automatic high_len(output int n);
    n = 0;
    while (cpu_reset === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic rc_stop();
    rc_run = 1'b0;
    cyc(10);
  endtask

  task automatic do_reset(input logic [7:0] cfg);
    @(negedge clk_sys);
    srst = 1'b1;
    cfg_byte_pins = cfg;
    rc_run = 1'b0;
    cyc(16);
    srst = 1'b0;
    cyc(2);
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog on the run itself
  // ----------------------------------------
  initial begin
    #(60000 * 25);
    err_total++;
    $display("unexpected run length: expected end, seen hang");
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int          t0;
    int          t1;
    int          n;
    int          s;
    int          sels[6];
    logic [2:0]  sv;
    logic [7:0]  bad;
    logic [15:0] ua;
    logic [31:0] r;
    sels = '{0, 1, 2, 3, 4, 7};
    {srst, rc_osc_pin, other_rst_pin, power_down, osc_stable} = 5'h10;
    {reg_wr, reg_rd, reg_addr, reg_wdata, cfg_byte_pins} = {2'h0, 16'h0000, 8'h00, 8'h7F};
    {err_total, num_checks, ticks, rc_run, rd_flag} = '0;
    rng = 32'h0000004F;
    // Interval mode: reset values and access kinds
    do_reset(8'h7F);
    chk("outputs after reset", 3'h0, {cpu_reset, osc_start, timer_irq});
    r = xrand();
    ua = {8'h10, r[7:0]};
    rd(`WDT_CFG1_ADDR, 8'h7F, "config byte");
    rd(`WDT_CTRL_ADDR, 8'h00, "control reg");
    rd(`WDT_FEED_ADDR, 8'h00, "feed reg");
    rd(ua, 8'h00, "unmapped read");
    wr(`WDT_CFG1_ADDR, r[15:8]);
    rd(`WDT_CFG1_ADDR, 8'h7F, "config after write");
    $display("test reset_values done");
    // Interval periods for a range of select codes
    rc_run = 1'b1;
    foreach (sels[i]) begin
      s = sels[i];
      sv = s[2:0];
      wr(`WDT_CTRL_ADDR, {5'h00, sv});
      wait_hi(1'b1, (16 << s) * 16 + 200, t0);
      rd(`WDT_CTRL_ADDR, {3'h1, 1'b1, 1'b0, sv}, "control flag");
      wr(`WDT_CTRL_ADDR, {5'h00, sv});
      cyc(2);
      chk("flag cleared", 1'b0, timer_irq);
      wait_hi(1'b1, (16 << s) * 8 + 80, t1);
      chk("interval ticks", 16 << s, t1 - t0);
      chk("no reset in interval mode", 1'b0, cpu_reset);
      wr(`WDT_CTRL_ADDR, {5'h00, sv});
    end
    $display("test interval_periods done");
    // Watchdog mode: one control write, wrong feed keeps schedule
    do_reset(8'hFF);
    rd(`WDT_CFG1_ADDR, 8'hFF, "config byte wd");
    rd(`WDT_CTRL_ADDR, 8'h40, "control wd mode");
    feed(ua, r[23:16]);
    t0 = ticks;
    wr(`WDT_CTRL_ADDR, 8'h01);
    rd(`WDT_CTRL_ADDR, 8'h61, "control locked");
    wr(`WDT_CTRL_ADDR, 8'h03);
    rd(`WDT_CTRL_ADDR, 8'h61, "control second write");
    cyc(200);
    chk("no expiry without rc ticks", 1'b0, cpu_reset);
    rc_run = 1'b1;
    while (ticks < t0 + 10) cyc(1);
    rc_stop();
    r = xrand();
    bad = (r[7:0] == 8'hE1 || r[7:0] == 8'h1E) ? 8'h00 : r[7:0];
    feed(`WDT_FEED_ADDR, bad);
    rc_run = 1'b1;
    wait_hi(1'b0, 40 * 8, t1);
    chk("expiry after bad feed", 32, t1 - t0);
    high_len(n);
    chk("reset pulse cycles", 40, n);
    rd(`WDT_CTRL_ADDR, 8'h40, "control after wd reset");
    $display("test watchdog_lock done");
    // Valid feed with a foreign write inside restarts the full period
    rc_stop();
    feed(ua, r[15:8]);
    rc_run = 1'b1;
    t0 = ticks;
    while (ticks < t0 + 12) cyc(1);
    rc_stop();
    feed(ua, r[23:16]);
    t0 = ticks;
    rc_run = 1'b1;
    wait_hi(1'b0, 30 * 8, t1);
    chk("expiry after feed", 16, t1 - t0);
    high_len(n);
    chk("second reset pulse", 40, n);
    $display("test feed_restart done");
    // Other reset holds the count; expiry from power-down waits for oscillator
    other_rst_pin = 1'b1;
    power_down = 1'b1;
    t0 = ticks;
    while (ticks < t0 + 40) cyc(1);
    chk("held by other reset", 1'b0, cpu_reset);
    rc_stop();
    other_rst_pin = 1'b0;
    cyc(5);
    t0 = ticks;
    rc_run = 1'b1;
    wait_hi(1'b0, 30 * 8, t1);
    chk("expiry after other reset", 16, t1 - t0);
    cyc(60);
    chk("held for oscillator", 2'h3, {cpu_reset, osc_start});
    osc_stable = 1'b1;
    cyc(6);
    chk("released on stable", 2'h0, {cpu_reset, osc_start});
    power_down = 1'b0;
    rc_run = 1'b0;
    cyc(4);
    $display("test power_down done");
    complete_run();
  end
endmodule // watchdog_interval_timer_tb
